//--- afpm_clip.sv
`timescale 1ns/100ps
`include "afpm_params.svh"
module afpm_clip
(
    // Sample in and clip level
    input  wire logic [`AFPM_SAMPLE_W-1:0] din,
    input  wire logic [`AFPM_CLIP_W-1:0]   level,
    // Sample out
    output logic      [`AFPM_SAMPLE_W-1:0] dout
);
    // ------------------------------------------------------------
    // Symmetric saturation
    // ------------------------------------------------------------
    wire logic [`AFPM_SAMPLE_W-1:0] pos_lim = {{(`AFPM_SAMPLE_W-`AFPM_CLIP_W){1'b0}}, level};
    wire logic [`AFPM_SAMPLE_W-1:0] neg_lim = (~pos_lim) + 1'b1;
    wire logic over  = ($signed(din) > $signed(pos_lim));
    wire logic under = ($signed(din) < $signed(neg_lim));
    assign dout = over ? pos_lim : (under ? neg_lim : din);
endmodule

//--- afpm_host_model.sv
`timescale 1ns/100ps
module afpm_host_model
(
    // Clock
    input  wire logic       clk,
    // Fault net and control
    input  wire logic       fault_n,
    input  wire logic       auto_en,
    input  wire logic [7:0] delay,
    // Shutdown pin
    output logic            sd_n
);
    int   wait_q;
    logic done_q;
    initial
    begin
        sd_n   = 1'b1;
        wait_q = 0;
        done_q = 1'b0;
    end
    // Fault seen: hold off, pulse shutdown low once, release
    always @(negedge clk)
    begin
        if (!auto_en || fault_n)
        begin
            wait_q <= 0;
            done_q <= 1'b0;
            sd_n   <= 1'b1;
        end
        else if (!done_q)
        begin
            wait_q <= wait_q + 1;
            sd_n   <= (wait_q >= delay && wait_q < delay + 4) ? 1'b0 : 1'b1;
            done_q <= (wait_q >= delay + 4);
        end
    end
endmodule

//--- afpm_params.svh
`ifndef AFPM_PARAMS_SVH
`define AFPM_PARAMS_SVH

// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define AFPM_CLK_MHZ            200
`define AFPM_FAULT_TIMEOUT_MS   10
`define AFPM_FAULT_TIMEOUT_CYC  (`AFPM_FAULT_TIMEOUT_MS * 1000 * `AFPM_CLK_MHZ)
`define AFPM_DC_DETECT_MS       420
`define AFPM_DC_DETECT_CYC      (`AFPM_DC_DETECT_MS * 1000 * `AFPM_CLK_MHZ)
`define AFPM_DC_DUTY_PCT        60

// ------------------------------------------------------------
// Widths and field layout
// ------------------------------------------------------------
`define AFPM_SAMPLE_W           24
`define AFPM_CLIP_W             20
`define AFPM_PWM_W              10
`define AFPM_CNT_W              32
`define AFPM_MULT_W             8
`define AFPM_ERR_W              6
`define AFPM_ERR_OVE            0
`define AFPM_ERR_UVE            1
`define AFPM_ERR_CLK            2
`define AFPM_ERR_OCE            3
`define AFPM_ERR_DCE            4
`define AFPM_ERR_OTE            5
`define AFPM_ERR_RST            6'h00
`define AFPM_PWM_MID            10'h200

`endif

//--- afpm_pkg.sv
package afpm_pkg;
    typedef enum logic [3:0]
    {
        AFPM_SHUTDOWN = 4'b0001,
        AFPM_PLAY     = 4'b0010,
        AFPM_LATCHED  = 4'b0100,
        AFPM_TIMEOUT  = 4'b1000
    } afpm_state_t;
endpackage

//--- afpm_properties.sv
`timescale 1ns/100ps
`include "afpm_params.svh"
module afpm_properties
#(
    parameter int FAULT_TIMEOUT_CYC = 20,
    parameter int DC_DETECT_CYC     = 50
)
(
    // Clock and reset
    input wire logic                   CLK_SYS,
    input wire logic                   RST,
    // Error causes
    input wire logic                   SUPPLY_ABOVE_OV,
    input wire logic                   CURRENT_ABOVE_OC,
    input wire logic                   CLK_RATIO_BAD,
    input wire logic                   CLK_RATE_BAD,
    input wire logic                   CLK_STOPPED,
    // Design outputs
    input wire logic                   SPEAKER_FAULT_N_O,
    input wire logic                   SPEAKER_FAULT_N_OE,
    input wire logic [`AFPM_ERR_W-1:0] ERROR_STATUS,
    input wire logic                   PLAYING,
    input wire logic [1:0]             PWM_P,
    input wire logic [1:0]             PWM_N
);
    // ------------------------------------------------------------
    // Fault pin low time
    // ------------------------------------------------------------
    logic        clk_err;
    logic [31:0] oe_cnt_q;
    logic [31:0] oe_cnt_d;
    assign clk_err  = CLK_RATIO_BAD | CLK_RATE_BAD | CLK_STOPPED;
    assign oe_cnt_d = SPEAKER_FAULT_N_OE ? oe_cnt_q + 32'h0000_0001 : 32'h0000_0000;
    always_ff @(posedge CLK_SYS)
    begin
        oe_cnt_q <= RST ? 32'h0000_0000 : oe_cnt_d;
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    a_pin_pulls_low: assert property (SPEAKER_FAULT_N_O == 1'b0)
        else $error("fault pin output not low");
    a_fault_has_cause: assert property ($rose(SPEAKER_FAULT_N_OE) |-> ERROR_STATUS[5:2] != 4'h0)
        else $error("fault pin low without clock or latching error");
    a_ov_reported: assert property (SUPPLY_ABOVE_OV ##1 SUPPLY_ABOVE_OV |-> ##1 ERROR_STATUS[0])
        else $error("overvoltage status missing");
    a_clk_err_fault: assert property (clk_err ##1 clk_err |-> ##1 (SPEAKER_FAULT_N_OE && ERROR_STATUS[2] && !PLAYING))
        else $error("clock error not on fault pin");
    a_clk_recovers: assert property ($fell(ERROR_STATUS[2]) && ERROR_STATUS[5:3] == 3'h0 |-> !SPEAKER_FAULT_N_OE)
        else $error("fault pin held after clock recovery");
    a_oc_latches: assert property (PLAYING && CURRENT_ABOVE_OC ##1 CURRENT_ABOVE_OC |-> ##1 (SPEAKER_FAULT_N_OE && ERROR_STATUS[3]))
        else $error("overcurrent not latched");
    a_latch_hold: assert property ($fell(SPEAKER_FAULT_N_OE) && $past(ERROR_STATUS[5:3]) != 3'h0 |-> PLAYING && oe_cnt_q >= FAULT_TIMEOUT_CYC)
        else $error("latched fault released early");
    a_no_play_fault: assert property (SPEAKER_FAULT_N_OE |-> !PLAYING)
        else $error("playing while fault pin low");
    a_pwm_pairs: assert property (PWM_N == ({2{PLAYING}} & ~PWM_P))
        else $error("pwm pair not complementary");
    a_quiet_stop: assert property (!PLAYING |-> PWM_P == 2'b00)
        else $error("pwm active while stopped");

    c_latch_recover: cover property ($fell(SPEAKER_FAULT_N_OE) && PLAYING);
    c_clock_error: cover property ($rose(ERROR_STATUS[2]));
    c_ov_error: cover property ($rose(ERROR_STATUS[0]));
endmodule

bind afpm_top afpm_properties #(.FAULT_TIMEOUT_CYC(FAULT_TIMEOUT_CYC), .DC_DETECT_CYC(DC_DETECT_CYC))
    u_props (.CLK_SYS(CLK_SYS), .RST(RST), .SUPPLY_ABOVE_OV(SUPPLY_ABOVE_OV),
             .CURRENT_ABOVE_OC(CURRENT_ABOVE_OC), .CLK_RATIO_BAD(CLK_RATIO_BAD),
             .CLK_RATE_BAD(CLK_RATE_BAD), .CLK_STOPPED(CLK_STOPPED),
             .SPEAKER_FAULT_N_O(SPEAKER_FAULT_N_O), .SPEAKER_FAULT_N_OE(SPEAKER_FAULT_N_OE),
             .ERROR_STATUS(ERROR_STATUS), .PLAYING(PLAYING), .PWM_P(PWM_P), .PWM_N(PWM_N));

//--- afpm_pwm.sv
`timescale 1ns/100ps
`include "afpm_params.svh"
module afpm_pwm
(
    // Clock and reset
    input  wire logic CLK_SYS,
    input  wire logic RST,
    input  wire logic CE,
    // Converter side
    afpm_pwm_if.conv  bus
);
    // ------------------------------------------------------------
    // Carrier counter, period = 1024 cycles, restarted by each sample strobe
    // ------------------------------------------------------------
    logic [`AFPM_PWM_W-1:0]  ramp_q;
    logic [`AFPM_MULT_W-1:0] rep_q;
    wire logic [`AFPM_PWM_W-1:0] ramp_d = ramp_q + 1'b1;
    wire logic wrap = (ramp_q == {`AFPM_PWM_W{1'b1}});

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            ramp_q <= '0;
            rep_q  <= '0;
        end
        else if (CE)
        begin
            ramp_q <= (bus.sample_stb) ? '0 : ramp_d;
            if (bus.sample_stb)
                rep_q <= '0;
            else if (wrap && rep_q != bus.mult)
                rep_q <= rep_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Per-channel complementary pair
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_ch
            wire logic [`AFPM_SAMPLE_W-1:0] smp = (ch == 0) ? bus.left : bus.right;
            wire logic [`AFPM_PWM_W-1:0] duty =
                {~smp[`AFPM_SAMPLE_W-1], smp[`AFPM_SAMPLE_W-2 -: `AFPM_PWM_W-1]};
            logic p_q;
            always_ff @(posedge CLK_SYS)
            begin
                if (RST)
                    p_q <= 1'b0;
                else if (CE)
                    p_q <= bus.en && (ramp_q < duty);
            end
            // Gate with enable so the pair goes quiet on the same edge as playback stops
            assign bus.p[ch] = bus.en && p_q;
            assign bus.n[ch] = bus.en && !p_q;
        end
    endgenerate
endmodule

//--- afpm_pwm_if.sv
`timescale 1ns/100ps
`include "afpm_params.svh"
interface afpm_pwm_if;
    logic                       en;
    logic                       sample_stb;
    logic [`AFPM_SAMPLE_W-1:0]  left;
    logic [`AFPM_SAMPLE_W-1:0]  right;
    logic [`AFPM_MULT_W-1:0]    mult;
    logic [1:0]                 p;
    logic [1:0]                 n;
    modport ctrl (output en, output sample_stb, output left, output right, output mult,
                  input p, input n);
    modport conv (input en, input sample_stb, input left, input right, input mult,
                  output p, output n);
endinterface

//--- afpm_top.sv
`timescale 1ns/100ps
`include "afpm_params.svh"
module afpm_top
#(
    parameter int FAULT_TIMEOUT_CYC = `AFPM_FAULT_TIMEOUT_CYC,
    parameter int DC_DETECT_CYC     = `AFPM_DC_DETECT_CYC
)
(
    // Clock, reset, enable
    input  wire logic                       CLK_SYS,
    input  wire logic                       RST,
    input  wire logic                       CE,
    // Shutdown controls, active low
    input  wire logic                       SPEAKER_SHUTDOWN_N,
    input  wire logic                       SHUTDOWN_BIT_N,
    // Analog monitor comparators
    input  wire logic                       SUPPLY_ABOVE_OV,
    input  wire logic                       SUPPLY_BELOW_UV,
    input  wire logic                       CURRENT_ABOVE_OC,
    input  wire logic                       TEMP_ABOVE_OT,
    input  wire logic                       TEMP_BELOW_HYST,
    // Clock checker flags
    input  wire logic                       CLK_RATIO_BAD,
    input  wire logic                       CLK_RATE_BAD,
    input  wire logic                       CLK_STOPPED,
    // Audio samples
    input  wire logic                       SAMPLE_STB,
    input  wire logic [`AFPM_SAMPLE_W-1:0]  SAMPLE_LEFT,
    input  wire logic [`AFPM_SAMPLE_W-1:0]  SAMPLE_RIGHT,
    // Configuration
    input  wire logic [`AFPM_CLIP_W-1:0]    CLIP_LEVEL,
    input  wire logic [`AFPM_MULT_W-1:0]    PWM_MULT,
    // Fault pin, open drain
    output logic                            SPEAKER_FAULT_N_O,
    output logic                            SPEAKER_FAULT_N_OE,
    // Status
    output logic [`AFPM_ERR_W-1:0]          ERROR_STATUS,
    output logic                            PLAYING,
    // PWM outputs
    output logic [1:0]                      PWM_P,
    output logic [1:0]                      PWM_N
);
    // ------------------------------------------------------------
    // Shutdown combine and edge detect
    // ------------------------------------------------------------
    wire logic sd_n = SPEAKER_SHUTDOWN_N && SHUTDOWN_BIT_N;
    logic sd_n_q;
    wire logic sd_rise = sd_n && !sd_n_q;

    // ------------------------------------------------------------
    // Raw conditions
    // ------------------------------------------------------------
    wire logic clk_err = CLK_RATIO_BAD || CLK_RATE_BAD || CLK_STOPPED;
    logic [`AFPM_CNT_W-1:0] dc_cnt_q [2];
    logic [1:0] dc_pol_q;
    logic [1:0] dc_hit;
    logic [`AFPM_SAMPLE_W-1:0] clip_l;
    logic [`AFPM_SAMPLE_W-1:0] clip_r;
    afpm_clip u_clip_l (.din(SAMPLE_LEFT),  .level(CLIP_LEVEL), .dout(clip_l));
    afpm_clip u_clip_r (.din(SAMPLE_RIGHT), .level(CLIP_LEVEL), .dout(clip_r));
    logic [`AFPM_SAMPLE_W-1:0] left_q;
    logic [`AFPM_SAMPLE_W-1:0] right_q;

    // ------------------------------------------------------------
    // DC detect per channel
    // ------------------------------------------------------------
    localparam logic [`AFPM_PWM_W-1:0] DUTY_HI =
        `AFPM_PWM_W'(((1 << `AFPM_PWM_W) * `AFPM_DC_DUTY_PCT) / 100);
    localparam logic [`AFPM_PWM_W-1:0] DUTY_LO =
        `AFPM_PWM_W'((1 << `AFPM_PWM_W) - DUTY_HI);
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_dc
            wire logic [`AFPM_SAMPLE_W-1:0] s = (ch == 0) ? left_q : right_q;
            wire logic [`AFPM_PWM_W-1:0] duty =
                {~s[`AFPM_SAMPLE_W-1], s[`AFPM_SAMPLE_W-2 -: `AFPM_PWM_W-1]};
            wire logic hi  = duty > DUTY_HI;
            wire logic lo  = duty < DUTY_LO;
            wire logic pol = hi;
            always_ff @(posedge CLK_SYS)
            begin
                if (RST)
                begin
                    dc_cnt_q[ch] <= '0;
                    dc_pol_q[ch] <= 1'b0;
                end
                else if (CE)
                begin
                    dc_pol_q[ch] <= pol;
                    if (!(hi || lo) || pol != dc_pol_q[ch])
                        dc_cnt_q[ch] <= '0;
                    else if (!dc_hit[ch])
                        dc_cnt_q[ch] <= dc_cnt_q[ch] + 1'b1;
                end
            end
            assign dc_hit[ch] = (dc_cnt_q[ch] > `AFPM_CNT_W'(DC_DETECT_CYC));
        end
    endgenerate
    wire logic dc_err = |dc_hit;

    // ------------------------------------------------------------
    // Latching fault state machine
    // ------------------------------------------------------------
    afpm_pkg::afpm_state_t st_q;
    afpm_pkg::afpm_state_t st_d;
    logic [`AFPM_CNT_W-1:0] tmo_q;
    logic oce_q;
    logic dce_q;
    logic ote_q;
    wire logic latch_cond = CURRENT_ABOVE_OC || dc_err || TEMP_ABOVE_OT;
    wire logic ote_hold   = ote_q && !TEMP_BELOW_HYST;
    wire logic tmo_done   = (tmo_q == '0);
    wire logic in_latch   = (st_q == afpm_pkg::AFPM_LATCHED) || (st_q == afpm_pkg::AFPM_TIMEOUT);

    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            afpm_pkg::AFPM_SHUTDOWN:
                if (sd_n)
                    st_d = latch_cond ? afpm_pkg::AFPM_LATCHED : afpm_pkg::AFPM_PLAY;
            afpm_pkg::AFPM_PLAY:
                if (!sd_n)
                    st_d = afpm_pkg::AFPM_SHUTDOWN;
                else if (latch_cond)
                    st_d = afpm_pkg::AFPM_LATCHED;
            afpm_pkg::AFPM_LATCHED:
                if (!sd_n)
                    st_d = afpm_pkg::AFPM_TIMEOUT;
            afpm_pkg::AFPM_TIMEOUT:
                if (sd_rise && latch_cond)
                    st_d = afpm_pkg::AFPM_LATCHED;
                else if (sd_n && tmo_done && !ote_hold)
                    st_d = afpm_pkg::AFPM_PLAY;
        endcase
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            st_q   <= afpm_pkg::AFPM_SHUTDOWN;
            sd_n_q <= 1'b0;
            tmo_q  <= '0;
            oce_q  <= 1'b0;
            dce_q  <= 1'b0;
            ote_q  <= 1'b0;
        end
        else if (CE)
        begin
            st_q   <= st_d;
            sd_n_q <= sd_n;
            if (st_d == afpm_pkg::AFPM_TIMEOUT && st_q == afpm_pkg::AFPM_LATCHED)
                tmo_q <= `AFPM_CNT_W'(FAULT_TIMEOUT_CYC);
            else if (!tmo_done)
                tmo_q <= tmo_q - 1'b1;
            // Sticky latched causes, set wins over clear
            oce_q <= CURRENT_ABOVE_OC || (oce_q && st_d != afpm_pkg::AFPM_PLAY);
            dce_q <= dc_err || (dce_q && st_d != afpm_pkg::AFPM_PLAY);
            ote_q <= TEMP_ABOVE_OT || (ote_q && st_d != afpm_pkg::AFPM_PLAY);
        end
    end

    // ------------------------------------------------------------
    // Status and fault pin
    // ------------------------------------------------------------
    logic [`AFPM_ERR_W-1:0] status_q;
    logic                   fault_q;
    wire logic [`AFPM_ERR_W-1:0] status_d;
    assign status_d[`AFPM_ERR_OVE] = SUPPLY_ABOVE_OV;
    assign status_d[`AFPM_ERR_UVE] = SUPPLY_BELOW_UV;
    assign status_d[`AFPM_ERR_CLK] = clk_err;
    assign status_d[`AFPM_ERR_OCE] = oce_q;
    assign status_d[`AFPM_ERR_DCE] = dce_q;
    assign status_d[`AFPM_ERR_OTE] = ote_q;
    wire logic nonlatch_block = SUPPLY_ABOVE_OV || SUPPLY_BELOW_UV || clk_err;
    wire logic play_d  = (st_q == afpm_pkg::AFPM_PLAY) && !nonlatch_block;
    wire logic fault_d = in_latch || clk_err;

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            status_q <= `AFPM_ERR_RST;
            fault_q  <= 1'b0;
            PLAYING  <= 1'b0;
            left_q   <= '0;
            right_q  <= '0;
        end
        else if (CE)
        begin
            status_q <= status_d;
            fault_q  <= fault_d;
            PLAYING  <= play_d;
            if (SAMPLE_STB)
            begin
                left_q  <= clip_l;
                right_q <= clip_r;
            end
        end
    end

    assign ERROR_STATUS       = status_q;
    assign SPEAKER_FAULT_N_O  = 1'b0;
    assign SPEAKER_FAULT_N_OE = fault_q;

    // ------------------------------------------------------------
    // PWM converter
    // ------------------------------------------------------------
    afpm_pwm_if pwm_bus ();
    assign pwm_bus.en         = PLAYING;
    assign pwm_bus.sample_stb = SAMPLE_STB;
    assign pwm_bus.left       = left_q;
    assign pwm_bus.right      = right_q;
    assign pwm_bus.mult       = PWM_MULT;
    afpm_pwm u_pwm (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .bus(pwm_bus));
    assign PWM_P = pwm_bus.p;
    assign PWM_N = pwm_bus.n;
endmodule

//--- tb_amp_fault_protection_manager.sv
`timescale 1ns/100ps
`include "afpm_params.svh"
module tb_amp_fault_protection_manager;
    localparam int TO = 20;
    logic        clk_sys  = 1'b0;
    logic        rst      = 1'b1;
    logic        sd_bit_n = 1'b1;
    logic        ov       = 1'b0;
    logic        uv       = 1'b0;
    logic        oc       = 1'b0;
    logic        ot       = 1'b0;
    logic        hyst     = 1'b1;
    logic [2:0]  clk_bad  = 3'b000;
    logic        stb      = 1'b0;
    logic [23:0] smp      = 24'h00_0000;
    logic        auto_en  = 1'b0;
    logic        host_sd_n;
    logic        fault_o;
    logic        fault_oe;
    logic        playing;
    logic        fault_net;
    logic [5:0]  status;
    logic [1:0]  pwm_p;
    logic [1:0]  pwm_n;
    int          fail_count  = 0;
    int          check_count = 0;

    always #2.5 clk_sys = ~clk_sys;
    assign fault_net = fault_oe ? fault_o : 1'b1;

    afpm_host_model host_u (.clk(clk_sys), .fault_n(fault_net), .auto_en(auto_en),
                            .delay(8'h05), .sd_n(host_sd_n));
    afpm_top #(.FAULT_TIMEOUT_CYC(TO), .DC_DETECT_CYC(50)) dut_u (
        .CLK_SYS(clk_sys), .RST(rst), .CE(1'b1), .SPEAKER_SHUTDOWN_N(host_sd_n),
        .SHUTDOWN_BIT_N(sd_bit_n), .SUPPLY_ABOVE_OV(ov), .SUPPLY_BELOW_UV(uv),
        .CURRENT_ABOVE_OC(oc), .TEMP_ABOVE_OT(ot), .TEMP_BELOW_HYST(hyst),
        .CLK_RATIO_BAD(clk_bad[0]), .CLK_RATE_BAD(clk_bad[1]), .CLK_STOPPED(clk_bad[2]),
        .SAMPLE_STB(stb), .SAMPLE_LEFT(smp), .SAMPLE_RIGHT(smp),
        .CLIP_LEVEL(20'h0_1000), .PWM_MULT(8'h00), .SPEAKER_FAULT_N_O(fault_o),
        .SPEAKER_FAULT_N_OE(fault_oe), .ERROR_STATUS(status), .PLAYING(playing),
        .PWM_P(pwm_p), .PWM_N(pwm_n));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_play(output int n);
        n = 0;
        while (playing !== 1'b1 && n < 400)
        begin
            cyc(1);
            n++;
        end
        chk("playing resumed", 8'h01, {7'h0, playing});
        if (n >= 400)
            print_verdict();
    endtask
    task automatic toggle();
        sd_bit_n = 1'b0;
        cyc(3);
        sd_bit_n = 1'b1;
    endtask
    task automatic duty(input logic [23:0] s, output int c);
        smp = s;
        stb = 1'b1;
        cyc(1);
        stb = 1'b0;
        c   = 0;
        repeat (1024)
        begin
            cyc(1);
            c += int'(pwm_p[0] === 1'b1);
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("oe in reset", 8'h00, {7'h0, fault_oe});
        rst = 1'b0;
        cyc(3);
        chk("playing", 8'h01, {7'h0, playing});
        chk("fault net", 8'h01, {7'h0, fault_net});
        $display("test reset done");
    endtask
    task automatic t_nonlatch();
        for (int i = 0; i < 2; i++)
        begin
            {uv, ov} = 2'b01 << i;
            cyc(3);
            chk("supply status", 8'h01 << i, {2'h0, status});
            chk("oe and playing", 8'h00, {6'h0, fault_oe, playing});
            {uv, ov} = 2'b00;
            cyc(3);
            chk("auto resume", 8'h01, {6'h0, fault_oe, playing});
        end
        $display("test nonlatch done");
    endtask
    task automatic t_clock();
        for (int i = 0; i < 3; i++)
        begin
            clk_bad = 3'b001 << i;
            cyc(3);
            chk("clock status", 8'h04, {2'h0, status});
            chk("clock fault", 8'h02, {6'h0, fault_oe, playing});
            clk_bad = 3'b000;
            cyc(3);
            chk("clock resume", 8'h01, {6'h0, fault_oe, playing});
        end
        $display("test clock done");
    endtask
    task automatic t_latch();
        int n;
        oc = 1'b1;
        cyc(2);
        oc = 1'b0;
        cyc(40);
        chk("oc latched", 8'h08, {2'h0, status});
        chk("oe held", 8'h02, {6'h0, fault_oe, playing});
        toggle();
        wait_play(n);
        chk("timeout met", 8'h01, {7'h0, n + 3 >= TO});
        chk("fault released", 8'h01, {7'h0, fault_net});
        $display("test latch done");
    endtask
    task automatic t_relatch();
        int n;
        oc = 1'b1;
        cyc(3);
        toggle();
        cyc(TO + 5);
        chk("relatched", 8'h22, {status, fault_oe, playing});
        oc = 1'b0;
        toggle();
        wait_play(n);
        chk("status cleared", 8'h00, {2'h0, status});
        $display("test relatch done");
    endtask
    task automatic t_ot();
        int n;
        ot   = 1'b1;
        hyst = 1'b0;
        cyc(2);
        ot = 1'b0;
        cyc(2);
        chk("ot status", 8'h20, {2'h0, status});
        toggle();
        cyc(TO + 10);
        chk("ot held", 8'h00, {7'h0, playing});
        hyst = 1'b1;
        toggle();
        wait_play(n);
        $display("test overtemp done");
    endtask
    task automatic t_partner();
        int n;
        auto_en = 1'b1;
        oc      = 1'b1;
        cyc(2);
        oc = 1'b0;
        cyc(3);
        chk("fault net low", 8'h00, {7'h0, fault_net});
        wait_play(n);
        chk("host released", 8'h03, {6'h0, fault_net, host_sd_n});
        auto_en = 1'b0;
        $display("test partner done");
    endtask
    task automatic t_clip();
        int a;
        int b;
        int z;
        duty(24'h00_1000, a);
        duty(24'h00_1000, a);
        duty(24'h00_4000, b);
        duty(24'hFF_F000, z);
        smp = 24'h00_0000;
        chk("clip equal", 8'h01, {7'h0, a == b});
        chk("polarity", 8'h01, {7'h0, a > z});
        $display("test clip done");
    endtask

    initial
    begin
        cyc(8);
        t_reset();
        t_nonlatch();
        t_clock();
        t_latch();
        t_relatch();
        t_ot();
        t_partner();
        t_clip();
        print_verdict();
    end
endmodule
